//--- tb/rcrd_decoder_sva.sv
// Port level checks of the command decoder
`timescale 1ns/1ps
`include "rcrd_consts.vh"
// ==========================================
// Checker
module rcrd_decoder_sva (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Configuration and power
  input wire tx_reg_enable,
  input wire fifo_mode_on,
  input wire [1:0] band_sel,
  input wire rf_front_en_q,
  input wire baseband_en_q,
  input wire synth_en_q,
  input wire osc_en_q,
  input wire pa_en_q,
  input wire tx_start_q,
  // Frequency and receiver
  input wire [11:0] freq_word,
  input wire [1:0] synth_c1_q,
  input wire [5:0] synth_c2_q,
  input wire [1:0] lna_gain_sel,
  input wire [2:0] rssi_thr_sel,
  input wire [7:0] rssi_eff_thr_q,
  input wire [1:0] vdi_resp_sel,
  input wire analog_filter_sel,
  input wire cr_enable_q,
  // Pins
  input wire pin20_out_q,
  input wire pin20_oe_q,
  input wire ext_int_evt_q,
  input wire rx_bit_clk_q
);
  // Expected band constants and threshold sum
  wire [1:0] c1_x = (band_sel == 2'h3) ? 2'h3 : (band_sel == 2'h2) ? 2'h2 : 2'h1;
  wire [5:0] c2_x = (band_sel == 2'h0) ? 6'h1f : (band_sel == 2'h3) ? 6'h1e : 6'h2b;
  wire [7:0] gain_x = (lna_gain_sel == 2'h0) ? `RCRD_GAIN_0 : (lna_gain_sel == 2'h1) ? `RCRD_GAIN_1 :
    (lna_gain_sel == 2'h2) ? `RCRD_GAIN_2 : `RCRD_GAIN_3;
  wire [7:0] eff_x = `RCRD_RSSI_BASE + {5'h00, rssi_thr_sel} * `RCRD_RSSI_STEP + gain_x;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_rx_chain_on: assert property (rf_front_en_q |-> baseband_en_q && synth_en_q && osc_en_q)
    else $error("receive chain partly off");
  a_tx_start_ok: assert property (tx_start_q |-> pa_en_q && synth_en_q && osc_en_q && $past(tx_reg_enable))
    else $error("transmit start without its enables");
  a_freq_legal: assert property (freq_word >= `RCRD_FREQ_MIN && freq_word <= `RCRD_FREQ_MAX)
    else $error("frequency word out of range");
  a_band_consts: assert property (synth_c1_q == $past(c1_x) && synth_c2_q == $past(c2_x))
    else $error("synthesizer constants wrong for band");
  a_rssi_sum: assert property (rssi_eff_thr_q == $past(eff_x))
    else $error("effective threshold wrong");
  a_filter_cr: assert property (cr_enable_q == !$past(analog_filter_sel))
    else $error("clock recovery on with analog filter");
  a_flag_forced: assert property ($past(vdi_resp_sel) == 2'h3 && pin20_oe_q |-> pin20_out_q)
    else $error("forced flag not high");
  a_ext_pulse: assert property (ext_int_evt_q |-> !pin20_oe_q ##1 !ext_int_evt_q)
    else $error("input event while pin drives");
  a_bit_clk: assert property (rx_bit_clk_q |-> !$past(fifo_mode_on))
    else $error("bit clock pulse in fifo mode");
  c_tx_start: cover property (tx_start_q);
  c_ext_int: cover property (ext_int_evt_q);
  c_bit_clk: cover property (rx_bit_clk_q);
  c_forced: cover property (pin20_oe_q && pin20_out_q);
endmodule // rcrd_decoder_sva
bind rcrd_decoder rcrd_decoder_sva u_sva (.mclk(mclk), .reset_n(reset_n), .tx_reg_enable(tx_reg_enable),
  .fifo_mode_on(fifo_mode_on), .band_sel(band_sel), .rf_front_en_q(rf_front_en_q), .baseband_en_q(baseband_en_q),
  .synth_en_q(synth_en_q), .osc_en_q(osc_en_q), .pa_en_q(pa_en_q), .tx_start_q(tx_start_q), .freq_word(freq_word),
  .synth_c1_q(synth_c1_q), .synth_c2_q(synth_c2_q), .lna_gain_sel(lna_gain_sel), .rssi_thr_sel(rssi_thr_sel),
  .rssi_eff_thr_q(rssi_eff_thr_q), .vdi_resp_sel(vdi_resp_sel), .analog_filter_sel(analog_filter_sel),
  .cr_enable_q(cr_enable_q), .pin20_out_q(pin20_out_q), .pin20_oe_q(pin20_oe_q), .ext_int_evt_q(ext_int_evt_q),
  .rx_bit_clk_q(rx_bit_clk_q));

//--- tb/rcrd_host_model.sv
// Host side model of the serial control pins
`timescale 1ns/1ps
// ==========================================
// Serial command master
module rcrd_host_model (
  // Clock and device answer
  input wire mclk,
  input wire sdo_q,
  // Serial pins
  output reg sck,
  output reg sdi,
  output reg chip_sel_n
);
  // Idle pins, clock parked low outside frames
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    chip_sel_n = 1'b1;
  end
  // One frame of n bits, 125 ns clock, answer bits collected on rises
  task xfer(input [15:0] w, input [4:0] n, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      @(posedge mclk);
      chip_sel_n <= 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        sdi <= w[15 - i];
        repeat (12) @(posedge mclk);
        rd = {rd[6:0], sdo_q};
        sck <= 1'b1;
        repeat (13) @(posedge mclk);
        sck <= 1'b0;
      end
      repeat (12) @(posedge mclk);
      chip_sel_n <= 1'b1;
      sdi <= ~sdi;
      repeat (12) @(posedge mclk);
    end
  endtask
endmodule // rcrd_host_model

//--- tb/test_radio_command_register_decoder.sv
// Self-checking bench of the command decoder
`timescale 1ns/1ps
`include "rcrd_consts.vh"
// ==========================================
// Bench top
module test_radio_command_register_decoder;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg rx_bit_in = 1'b0, rx_bit_valid = 1'b0, cr_locked = 1'b0, pin20_in = 1'b1, seen_clk = 1'b0, vdi_in = 1'b0;
  wire sck, sdi, chip_sel_n, sdo_q, rx_bit_ready_q, rx_data_out_q, rx_bit_clk_q, pin20_out_q, pin20_oe_q;
  wire ext_int_evt_q, fifo_it_q, tx_reg_enable, fifo_mode_on, rf_front_en_q, baseband_en_q, synth_en_q, osc_en_q;
  wire pa_en_q, tx_start_q, lowbatt_det_on_q, wake_timer_on_q, clkout_en_q, rate_prescale_sel, cr_enable_q, cr_fast_q;
  wire analog_filter_sel, sensitive_reset_off;
  wire [1:0] band_sel, synth_c1_q, vdi_resp_sel, lna_gain_sel;
  wire [2:0] bb_bw_sel, rssi_thr_sel, quality_detect_thr;
  wire [3:0] xtal_cap_sel;
  wire [5:0] synth_c2_q;
  wire [6:0] rate_div;
  wire [7:0] rssi_eff_thr_q;
  wire [11:0] freq_word;
  integer n_mismatch = 0, comparisons = 0, b;
  reg [7:0] rd;
  reg [3:0] na;
  rcrd_decoder u_dut (.mclk(mclk), .reset_n(reset_n), .sck(sck), .sdi(sdi), .chip_sel_n(chip_sel_n), .sdo_q(sdo_q),
    .rx_bit_in(rx_bit_in), .rx_bit_valid(rx_bit_valid), .rx_bit_ready_q(rx_bit_ready_q), .cr_locked(cr_locked),
    .vdi_in(vdi_in), .rx_data_out_q(rx_data_out_q), .rx_bit_clk_q(rx_bit_clk_q), .pin20_in(pin20_in),
    .pin20_out_q(pin20_out_q), .pin20_oe_q(pin20_oe_q), .ext_int_evt_q(ext_int_evt_q), .fifo_it_q(fifo_it_q),
    .tx_reg_enable(tx_reg_enable), .fifo_mode_on(fifo_mode_on), .band_sel(band_sel), .xtal_cap_sel(xtal_cap_sel),
    .rf_front_en_q(rf_front_en_q), .baseband_en_q(baseband_en_q), .synth_en_q(synth_en_q), .osc_en_q(osc_en_q),
    .pa_en_q(pa_en_q), .tx_start_q(tx_start_q), .lowbatt_det_on_q(lowbatt_det_on_q),
    .wake_timer_on_q(wake_timer_on_q), .clkout_en_q(clkout_en_q), .freq_word(freq_word), .synth_c1_q(synth_c1_q),
    .synth_c2_q(synth_c2_q), .rate_div(rate_div), .rate_prescale_sel(rate_prescale_sel),
    .vdi_resp_sel(vdi_resp_sel), .bb_bw_sel(bb_bw_sel), .lna_gain_sel(lna_gain_sel), .rssi_thr_sel(rssi_thr_sel),
    .rssi_eff_thr_q(rssi_eff_thr_q), .cr_enable_q(cr_enable_q), .cr_fast_q(cr_fast_q),
    .analog_filter_sel(analog_filter_sel), .quality_detect_thr(quality_detect_thr),
    .sensitive_reset_off(sensitive_reset_off));
  rcrd_host_model u_host (.mclk(mclk), .sdo_q(sdo_q), .sck(sck), .sdi(sdi), .chip_sel_n(chip_sel_n));
  // Clock and bit clock pulse catcher
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rx_bit_clk_q) seen_clk <= 1'b1;
  end
  // ==========================================
  // Helpers
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (n_mismatch == 0 && comparisons > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task wr(input [15:0] w);
    begin
      u_host.xfer(w, 5'h10, rd);
      repeat (8) @(posedge mclk);
    end
  endtask
  // Offer one bit, stalled offers give up after 20 cycles
  task sbit(input v, output ok);
    integer i;
    begin
      ok = 1'b0;
      rx_bit_in <= v;
      rx_bit_valid <= 1'b1;
      for (i = 0; i < 20 && !ok; i = i + 1) begin
        @(posedge mclk);
        if (rx_bit_ready_q === 1'b1) ok = 1'b1;
      end
      rx_bit_valid <= 1'b0;
      rx_bit_in <= ~v;
      @(posedge mclk);
    end
  endtask
  task sbyte(input [7:0] v, output [3:0] n);
    integer i;
    reg ok;
    begin
      n = 4'h0;
      ok = 1'b1;
      for (i = 7; i >= 0 && ok; i = i - 1) begin
        sbit(v[i], ok);
        if (ok) n = n + 4'h1;
      end
    end
  endtask
  // ==========================================
  // Scenarios
  task t_defaults;
    begin
      chk({tx_reg_enable, fifo_mode_on, band_sel, xtal_cap_sel}, `RCRD_CFG_RST & 16'h00ff);
      chk({rf_front_en_q, baseband_en_q, synth_en_q, osc_en_q, pa_en_q, tx_start_q, lowbatt_det_on_q,
        wake_timer_on_q, clkout_en_q}, 16'h0021);
      chk(freq_word, `RCRD_FREQ_RST & 16'h0fff);
      chk({rate_prescale_sel, rate_div}, `RCRD_RATE_RST & 16'h00ff);
      chk({pin20_oe_q, vdi_resp_sel, bb_bw_sel, lna_gain_sel, rssi_thr_sel}, `RCRD_RXC_RST & 16'h07ff);
      chk({rssi_eff_thr_q, cr_enable_q, cr_fast_q, analog_filter_sel, quality_detect_thr}, 16'h2664);
      chk({fifo_it_q, sensitive_reset_off}, 16'h0000);
    end
  endtask
  task t_bands;
    for (b = 0; b < 4; b = b + 1) begin
      wr(16'h8080 | (b << 4) | (b * 5));
      chk({tx_reg_enable, band_sel, xtal_cap_sel}, 16'h0040 | (b << 4) | (b * 5));
      chk({synth_c1_q, synth_c2_q}, b == 0 ? 16'h5f : b == 1 ? 16'h6b : b == 2 ? 16'hab : 16'hde);
    end
  endtask
  task t_power;
    begin
      wr(16'h8220);
      chk({rf_front_en_q, baseband_en_q, synth_en_q, osc_en_q, pa_en_q, tx_start_q}, 16'h0f);
      wr(16'h8280);
      chk({rf_front_en_q, baseband_en_q, synth_en_q, osc_en_q, pa_en_q, tx_start_q}, 16'h3c);
      wr(16'h8247);
      chk({baseband_en_q, synth_en_q, osc_en_q, lowbatt_det_on_q, wake_timer_on_q, clkout_en_q}, 16'h26);
    end
  endtask
  task fw(input [15:0] w, input [15:0] e);
    begin
      wr(w);
      chk(freq_word, e);
    end
  endtask
  task t_freq;
    begin
      fw(16'ha060, 16'h060);
      fw(16'haf3f, 16'hf3f);
      fw(16'ha05f, 16'hf3f);
      fw(16'haf40, 16'hf3f);
      u_host.xfer(16'ha123, 5'h08, rd);
      wr(16'he123);
      chk(freq_word, 16'hf3f);
      wr(16'hc6ff);
      chk({rate_prescale_sel, rate_div}, 16'h00ff);
    end
  endtask
  task t_rxc;
    integer i;
    begin
      wr(16'h97ff);
      chk({pin20_oe_q, vdi_resp_sel, bb_bw_sel, lna_gain_sel, rssi_thr_sel, pin20_out_q}, 16'h0fff);
      chk(rssi_eff_thr_q, 16'h00af);
      wr(16'h9420);
      vdi_in <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({pin20_oe_q, pin20_out_q}, 16'h3);
      vdi_in <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(pin20_out_q, 16'h0);
      wr(16'h9013);
      chk({pin20_oe_q, rssi_eff_thr_q}, 16'h009d);
      pin20_in <= 1'b0;
      for (i = 0; i < 10 && ext_int_evt_q !== 1'b1; i = i + 1) @(posedge mclk);
      chk(ext_int_evt_q, 1'b1);
      pin20_in <= 1'b1;
    end
  endtask
  task t_filter;
    begin
      wr(16'hc21f);
      chk({cr_enable_q, analog_filter_sel, quality_detect_thr}, 16'h0f);
      wr(16'hc2ec);
      chk({cr_enable_q, cr_fast_q}, 16'h3);
      cr_locked <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(cr_fast_q, 1'b0);
      wr(16'hc24c);
      chk(cr_fast_q, 1'b1);
    end
  endtask
  task t_stream;
    reg ok;
    begin
      seen_clk <= 1'b0;
      sbit(1'b1, ok);
      @(posedge mclk);
      chk({ok, rx_data_out_q, seen_clk}, 16'h7);
      wr(16'h8040);
      wr(16'hca83);
      chk(sensitive_reset_off, 16'h1);
      sbyte(8'h2d, na);
      sbyte(8'hd4, na);
      sbyte(8'ha5, na);
      sbyte(8'h3c, na);
      sbyte(8'hff, na);
      chk({rx_bit_ready_q, fifo_it_q, na < 4'h8}, 16'h3);
      u_host.xfer(16'hb000, 5'h10, rd);
      chk(rd, 16'ha5);
      u_host.xfer(16'hb000, 5'h10, rd);
      chk(rd, 16'h3c);
      u_host.xfer(16'hb000, 5'h10, rd);
      chk({rd, fifo_it_q}, 16'h0);
      // Clear and set the fill bit, start filling without the pattern
      wr(16'hca81);
      wr(16'hca87);
      sbyte(8'h5a, na);
      u_host.xfer(16'hb000, 5'h10, rd);
      chk({rd, na}, 16'h5a8);
    end
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_defaults;
    t_bands;
    t_power;
    t_freq;
    t_rxc;
    t_filter;
    t_stream;
    wrap_up;
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule // test_radio_command_register_decoder

//--- verilog/rcrd_consts.vh
// Constants for the radio command register decoder
`ifndef RCRD_CONSTS_VH
`define RCRD_CONSTS_VH
// ==========================================
// Power-on defaults of the command registers
`define RCRD_CFG_RST 16'h8008
`define RCRD_PWR_RST 16'h8208
`define RCRD_FREQ_RST 16'ha680
`define RCRD_RATE_RST 16'hc623
`define RCRD_RXC_RST 16'h9080
`define RCRD_FILT_RST 16'hc22c
`define RCRD_FIFO_RST 16'hca80
// ==========================================
// Command codes in the leading bits
`define RCRD_OP_CFG 8'h80
`define RCRD_OP_PWR 8'h82
`define RCRD_OP_FREQ 4'ha
`define RCRD_OP_RATE 8'hc6
`define RCRD_OP_RXC 5'h12
`define RCRD_OP_FILT 8'hc2
`define RCRD_OP_FIFO 8'hca
`define RCRD_OP_FRD 8'hb0
// ==========================================
// Serial framing
`define RCRD_CMD_BITS 5'h10
`define RCRD_RD_START 5'h08
// ==========================================
// Frequency word limits, 96 and 3903
`define RCRD_FREQ_MIN 12'h060
`define RCRD_FREQ_MAX 12'hf3f
// ==========================================
// Synchronous pattern
`define RCRD_SYNC 16'h2dd4
// ==========================================
// Field positions
`define RCRD_B_TXREG 7
`define RCRD_B_FIFOMODE 6
`define RCRD_B_ER 7
`define RCRD_B_EBB 6
`define RCRD_B_ET 5
`define RCRD_B_ES 4
`define RCRD_B_EX 3
`define RCRD_B_EB 2
`define RCRD_B_EW 1
`define RCRD_B_DC 0
`define RCRD_B_PIN20 10
`define RCRD_B_AUTOLOCK 7
`define RCRD_B_LOCKSPD 6
`define RCRD_B_ANALOG 4
`define RCRD_B_FILLSTART 2
`define RCRD_B_FILL 1
`define RCRD_B_SENSRST 0
// ==========================================
// RSSI threshold: base -103 dBm, 6 dB step, LNA gains
`define RCRD_RSSI_BASE 8'h99
`define RCRD_RSSI_STEP 8'h06
`define RCRD_GAIN_0 8'h00
`define RCRD_GAIN_1 8'hfa
`define RCRD_GAIN_2 8'hf2
`define RCRD_GAIN_3 8'hec
`endif

//--- verilog/rcrd_decoder.v
// Serial command decoder and configuration registers for the transceiver
`timescale 1ns/1ps
`include "rcrd_consts.vh"
// ==========================================
module rcrd_decoder #(
  parameter BUF_DW = 8,
  parameter BUF_AW = 1
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Serial control interface
  input wire sck,
  input wire sdi,
  input wire chip_sel_n,
  output reg sdo_q,
  // Demodulated receive bits
  input wire rx_bit_in,
  input wire rx_bit_valid,
  output reg rx_bit_ready_q,
  input wire cr_locked,
  input wire vdi_in,
  // Direct data pins when FIFO mode is off
  output reg rx_data_out_q,
  output reg rx_bit_clk_q,
  // Shared interrupt input or flag output pin
  input wire pin20_in,
  output reg pin20_out_q,
  output reg pin20_oe_q,
  output reg ext_int_evt_q,
  // FIFO level interrupt
  output reg fifo_it_q,
  // Configuration fields
  output wire tx_reg_enable,
  output wire fifo_mode_on,
  output wire [1:0] band_sel,
  output wire [3:0] xtal_cap_sel,
  // Power enables
  output reg rf_front_en_q,
  output reg baseband_en_q,
  output reg synth_en_q,
  output reg osc_en_q,
  output reg pa_en_q,
  output reg tx_start_q,
  output reg lowbatt_det_on_q,
  output reg wake_timer_on_q,
  output reg clkout_en_q,
  // Frequency
  output wire [11:0] freq_word,
  output reg [1:0] synth_c1_q,
  output reg [5:0] synth_c2_q,
  // Data rate
  output wire [6:0] rate_div,
  output wire rate_prescale_sel,
  // Receiver control
  output wire [1:0] vdi_resp_sel,
  output wire [2:0] bb_bw_sel,
  output wire [1:0] lna_gain_sel,
  output wire [2:0] rssi_thr_sel,
  output reg [7:0] rssi_eff_thr_q,
  // Data filter
  output reg cr_enable_q,
  output reg cr_fast_q,
  output wire analog_filter_sel,
  output wire [2:0] quality_detect_thr,
  // Reset mode
  output wire sensitive_reset_off
);

  // Fill states
  localparam ST_IDLE = 3'b001;
  localparam ST_HUNT = 3'b010;
  localparam ST_FILL = 3'b100;
  localparam BUF_DEPTH = 1 << BUF_AW;

  reg [15:0] cfg_q, pwr_q, freq_q, rate_q, rxc_q, filt_q, fifo_q;
  reg [1:0] sck_sync_q, sdi_sync_q, cs_sync_q, p20_sync_q;
  reg sck_d_q, p20_d_q;
  reg [4:0] bit_cnt_q;
  reg [14:0] shift_q;
  reg [7:0] rd_shift_q;
  reg rd_act_q;
  reg [2:0] state_q;
  reg [15:0] pat_q;
  reg [7:0] asm_q;
  reg [2:0] asm_cnt_q;
  reg [BUF_DW-1:0] buf_mem [0:BUF_DEPTH-1];
  reg [BUF_AW-1:0] wr_ptr_q, rd_ptr_q;
  reg [BUF_AW:0] buf_cnt_q;

  wire sck_s = sck_sync_q[1];
  wire sdi_s = sdi_sync_q[1];
  wire cs_n_s = cs_sync_q[1];
  wire p20_s = p20_sync_q[1];
  wire sck_rise = sck_s & ~sck_d_q;
  wire sck_fall = ~sck_s & sck_d_q;
  wire [15:0] word = {shift_q, sdi_s};
  wire word_done = sck_rise & ~cs_n_s & (bit_cnt_q == `RCRD_CMD_BITS - 5'h01);
  wire fifo_active = cfg_q[`RCRD_B_FIFOMODE] & ~filt_q[`RCRD_B_ANALOG];
  wire fill_on = fifo_q[`RCRD_B_FILL] & fifo_active;
  wire rx_take = rx_bit_valid & rx_bit_ready_q;
  wire buf_full = (buf_cnt_q == BUF_DEPTH[BUF_AW:0]);
  wire buf_empty = (buf_cnt_q == {(BUF_AW+1){1'b0}});
  wire rd_start = sck_rise & ~cs_n_s & (bit_cnt_q == `RCRD_RD_START - 5'h01) &&
    ({shift_q[6:0], sdi_s} == `RCRD_OP_FRD);
  wire buf_pop = rd_start & ~buf_empty;
  wire buf_push = (state_q == ST_FILL) & rx_take & (asm_cnt_q == 3'h7);
  wire [15:0] pat_next = {pat_q[14:0], rx_bit_in};
  wire [11:0] freq_new = word[11:0];

  // Field views of the command registers
  assign tx_reg_enable = cfg_q[`RCRD_B_TXREG];
  assign fifo_mode_on = cfg_q[`RCRD_B_FIFOMODE];
  assign band_sel = cfg_q[5:4];
  assign xtal_cap_sel = cfg_q[3:0];
  assign freq_word = freq_q[11:0];
  assign rate_div = rate_q[6:0];
  assign rate_prescale_sel = rate_q[7];
  assign vdi_resp_sel = rxc_q[9:8];
  assign bb_bw_sel = rxc_q[7:5];
  assign lna_gain_sel = rxc_q[4:3];
  assign rssi_thr_sel = rxc_q[2:0];
  assign analog_filter_sel = filt_q[`RCRD_B_ANALOG];
  assign quality_detect_thr = filt_q[2:0];
  assign sensitive_reset_off = fifo_q[`RCRD_B_SENSRST];

  // ==========================================
  // Pin synchronisers
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      cs_sync_q <= 2'h3;
      p20_sync_q <= 2'h3;
      sck_d_q <= 1'b0;
      p20_d_q <= 1'b1;
    end else begin
      sck_sync_q <= {sck_sync_q[0], sck};
      sdi_sync_q <= {sdi_sync_q[0], sdi};
      cs_sync_q <= {cs_sync_q[0], chip_sel_n};
      p20_sync_q <= {p20_sync_q[0], pin20_in};
      sck_d_q <= sck_s;
      p20_d_q <= p20_s;
    end
  end

  // ==========================================
  // Serial shifter and FIFO read output
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 15'h0000;
      rd_shift_q <= 8'h00;
      rd_act_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (cs_n_s) begin
      bit_cnt_q <= 5'h00;
      rd_act_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      if (sck_rise && bit_cnt_q != `RCRD_CMD_BITS) begin
        shift_q <= word[14:0];
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (rd_start) begin
        rd_shift_q <= buf_empty ? 8'h00 : buf_mem[rd_ptr_q];
        rd_act_q <= 1'b1;
      end else if (sck_fall && rd_act_q) begin
        sdo_q <= rd_shift_q[7];
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
      if (word_done) begin
        rd_act_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Command decode into registers
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= `RCRD_CFG_RST;
      pwr_q <= `RCRD_PWR_RST;
      freq_q <= `RCRD_FREQ_RST;
      rate_q <= `RCRD_RATE_RST;
      rxc_q <= `RCRD_RXC_RST;
      filt_q <= `RCRD_FILT_RST;
      fifo_q <= `RCRD_FIFO_RST;
    end else if (word_done) begin
      if (word[15:8] == `RCRD_OP_CFG) begin
        cfg_q <= word;
      end else if (word[15:8] == `RCRD_OP_PWR) begin
        pwr_q <= word;
      end else if (word[15:12] == `RCRD_OP_FREQ) begin
        if (freq_new >= `RCRD_FREQ_MIN && freq_new <= `RCRD_FREQ_MAX) begin
          freq_q <= word;
        end
      end else if (word[15:8] == `RCRD_OP_RATE) begin
        rate_q <= word;
      end else if (word[15:11] == `RCRD_OP_RXC) begin
        rxc_q <= word;
      end else if (word[15:8] == `RCRD_OP_FILT) begin
        filt_q <= word;
      end else if (word[15:8] == `RCRD_OP_FIFO) begin
        fifo_q <= word;
      end
    end
  end

  // ==========================================
  // Derived power, synthesizer and threshold outputs
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rf_front_en_q <= 1'b0;
      baseband_en_q <= 1'b0;
      synth_en_q <= 1'b0;
      osc_en_q <= 1'b0;
      pa_en_q <= 1'b0;
      tx_start_q <= 1'b0;
      lowbatt_det_on_q <= 1'b0;
      wake_timer_on_q <= 1'b0;
      clkout_en_q <= 1'b1;
      synth_c1_q <= 2'h1;
      synth_c2_q <= 6'h1f;
      rssi_eff_thr_q <= `RCRD_RSSI_BASE;
      cr_enable_q <= 1'b1;
      cr_fast_q <= 1'b0;
    end else begin
      rf_front_en_q <= pwr_q[`RCRD_B_ER];
      baseband_en_q <= pwr_q[`RCRD_B_ER] | pwr_q[`RCRD_B_EBB];
      synth_en_q <= pwr_q[`RCRD_B_ER] | pwr_q[`RCRD_B_ET] | pwr_q[`RCRD_B_ES];
      osc_en_q <= pwr_q[`RCRD_B_ER] | pwr_q[`RCRD_B_ET] | pwr_q[`RCRD_B_ES] | pwr_q[`RCRD_B_EX];
      pa_en_q <= pwr_q[`RCRD_B_ET];
      tx_start_q <= pwr_q[`RCRD_B_ET] & cfg_q[`RCRD_B_TXREG];
      lowbatt_det_on_q <= pwr_q[`RCRD_B_EB];
      wake_timer_on_q <= pwr_q[`RCRD_B_EW];
      clkout_en_q <= ~pwr_q[`RCRD_B_DC];
      // Band constants
      case (cfg_q[5:4])
        2'h0: begin
          synth_c1_q <= 2'h1;
          synth_c2_q <= 6'h1f;
        end
        2'h1: begin
          synth_c1_q <= 2'h1;
          synth_c2_q <= 6'h2b;
        end
        2'h2: begin
          synth_c1_q <= 2'h2;
          synth_c2_q <= 6'h2b;
        end
        default: begin
          synth_c1_q <= 2'h3;
          synth_c2_q <= 6'h1e;
        end
      endcase
      // Threshold plus LNA gain, signed dBm
      case (rxc_q[4:3])
        2'h0: rssi_eff_thr_q <= `RCRD_RSSI_BASE + `RCRD_RSSI_STEP * {5'h00, rxc_q[2:0]} + `RCRD_GAIN_0;
        2'h1: rssi_eff_thr_q <= `RCRD_RSSI_BASE + `RCRD_RSSI_STEP * {5'h00, rxc_q[2:0]} + `RCRD_GAIN_1;
        2'h2: rssi_eff_thr_q <= `RCRD_RSSI_BASE + `RCRD_RSSI_STEP * {5'h00, rxc_q[2:0]} + `RCRD_GAIN_2;
        default: rssi_eff_thr_q <= `RCRD_RSSI_BASE + `RCRD_RSSI_STEP * {5'h00, rxc_q[2:0]} + `RCRD_GAIN_3;
      endcase
      cr_enable_q <= ~filt_q[`RCRD_B_ANALOG];
      // Auto-lock runs fast until locked, then slow
      if (filt_q[`RCRD_B_AUTOLOCK]) begin
        cr_fast_q <= ~cr_locked;
      end else begin
        cr_fast_q <= filt_q[`RCRD_B_LOCKSPD];
      end
    end
  end

  // ==========================================
  // Shared pin and direct data output
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin20_out_q <= 1'b0;
      pin20_oe_q <= 1'b0;
      ext_int_evt_q <= 1'b0;
      rx_data_out_q <= 1'b0;
      rx_bit_clk_q <= 1'b0;
    end else begin
      pin20_oe_q <= rxc_q[`RCRD_B_PIN20];
      pin20_out_q <= rxc_q[`RCRD_B_PIN20] & (vdi_in | (rxc_q[9:8] == 2'h3));
      ext_int_evt_q <= ~rxc_q[`RCRD_B_PIN20] & p20_d_q & ~p20_s;
      rx_bit_clk_q <= ~cfg_q[`RCRD_B_FIFOMODE] & rx_take;
      if (~cfg_q[`RCRD_B_FIFOMODE] & rx_take) begin
        rx_data_out_q <= rx_bit_in;
      end
    end
  end

  // ==========================================
  // Pattern hunt and FIFO fill
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      pat_q <= 16'h0000;
      asm_q <= 8'h00;
      asm_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pat_q <= 16'h0000;
          asm_cnt_q <= 3'h0;
          if (fill_on) begin
            state_q <= fifo_q[`RCRD_B_FILLSTART] ? ST_FILL : ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (!fill_on) begin
            state_q <= ST_IDLE;
          end else if (rx_take) begin
            pat_q <= pat_next;
            if (pat_next == `RCRD_SYNC) begin
              state_q <= ST_FILL;
            end
          end
        end
        ST_FILL: begin
          if (!fill_on) begin
            state_q <= ST_IDLE;
          end else if (rx_take) begin
            asm_q <= {asm_q[6:0], rx_bit_in};
            asm_cnt_q <= asm_cnt_q + 3'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Two-entry byte buffer toward the host
  always @(posedge mclk) begin
    if (buf_push) begin
      buf_mem[wr_ptr_q] <= {asm_q[6:0], rx_bit_in};
    end
  end

  // Buffer pointers, ready and level interrupt
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= {BUF_AW{1'b0}};
      rd_ptr_q <= {BUF_AW{1'b0}};
      buf_cnt_q <= {(BUF_AW+1){1'b0}};
      rx_bit_ready_q <= 1'b1;
      fifo_it_q <= 1'b0;
    end else begin
      if (buf_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (buf_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (buf_push && !buf_pop) begin
        buf_cnt_q <= buf_cnt_q + 1'b1;
      end else if (buf_pop && !buf_push) begin
        buf_cnt_q <= buf_cnt_q - 1'b1;
      end
      // Stall the source before a byte would meet a full buffer
      rx_bit_ready_q <= ~(((state_q == ST_FILL) && rx_take ? (asm_cnt_q == 3'h6) : (asm_cnt_q == 3'h7)) &&
        ((buf_full && !buf_pop) || (buf_cnt_q == BUF_DEPTH[BUF_AW:0] - 1'b1 && buf_push && !buf_pop)));
      fifo_it_q <= fifo_active && ({buf_cnt_q, 3'h0} + {{BUF_AW{1'b0}}, asm_cnt_q} >= {{(BUF_AW){1'b0}}, fifo_q[7:4]});
    end
  end

endmodule // rcrd_decoder
